// ==== src/omc_top.sv ====
// Operating mode controller top module
`timescale 1ns/1ps
module omc_top #(
	parameter int RESET_DURATION_CYC = omc_pkg::RESET_DURATION_CYC,
	parameter int CONFIG_TIMEOUT_CYC = omc_pkg::CONFIG_TIMEOUT_CYC,
	parameter int CYCLIC_PERIOD = 1024,
	parameter int CYCLIC_ON = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire omc_pkg::omc_cmd_t mode_cmd,
	input wire logic wd_period_write,
	input wire logic [3:0] wd_period,
	input wire logic wd_timeout,
	input wire logic wd_closed_trigger,
	input wire logic stop_watchdog_enable,
	input wire logic switch_output_on_bit,
	input wire logic flag_clear,
	input wire logic vdd_undervoltage_pin,
	input wire logic second_supply_undervoltage_pin,
	input wire logic switch_overtemp_pin,
	input wire omc_pkg::omc_wake_t wake_pins,
	input wire logic can_rx_msg,
	output logic [5:0] mode,
	output logic reset_n,
	output logic irq_n,
	output logic main_regulator_on,
	output logic main_regulator_keepalive,
	output logic second_regulator_drive,
	output logic switched_battery_output,
	output logic can_tx_enable,
	output logic watchdog_run,
	output logic slow_osc_select,
	output logic second_supply_low_flag,
	output logic switch_overtemp_flag,
	output logic switch_overtemp_or_supply_low_irq,
	output logic can_wake_flag,
	output logic [3:0] wd_config
);
	// ------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------
	// Cyclic counter is 16 bits wide, timers 32 bits
	if (RESET_DURATION_CYC < 1 || CONFIG_TIMEOUT_CYC < 1 ||
		CYCLIC_ON < 1 || CYCLIC_ON >= CYCLIC_PERIOD ||
		CYCLIC_PERIOD > 65536) begin
		$error("omc_top: bad timing parameters");
	end
	// ------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------
	localparam int NS = 10;
	logic [NS-1:0] sync_a, sync_b;
	logic [NS-1:0] async_in;
	assign async_in = {vdd_undervoltage_pin, second_supply_undervoltage_pin,
		switch_overtemp_pin, can_rx_msg, wake_pins};
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= async_in;
			sync_b <= sync_a;
		end
	end
	logic vdd_uv, v2_uv, hs_ot, can_rx;
	omc_pkg::omc_wake_t wk;
	assign {vdd_uv, v2_uv, hs_ot, can_rx, wk} = sync_b;
	// ------------------------------------------------
	// State and timers
	// ------------------------------------------------
	omc_pkg::omc_mode_t state, next_state;
	logic [31:0] timer, next_timer;
	logic from_sleep, next_from_sleep;
	logic [15:0] pulse_cnt, next_pulse_cnt;
	logic [15:0] cyc_cnt, next_cyc_cnt;
	logic [1:0] div_cnt, next_div_cnt;
	logic [3:0] next_wd_config;
	logic tick;
	logic stop_wake, sleep_wake;
	assign stop_wake = |wk;
	assign sleep_wake = wk.cyclic_sense | wk.forced_timer | wk.can_msg |
		wk.wake_change;
	// Slow oscillator tick in Sleep and Stop
	assign tick = !(state inside {omc_pkg::OMC_SLEEP, omc_pkg::OMC_STOP}) ||
		div_cnt == 2'h0;
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_from_sleep = from_sleep;
		next_pulse_cnt = (pulse_cnt != 16'h0) ? pulse_cnt - 16'h1 : 16'h0;
		next_wd_config = wd_config;
		next_div_cnt = (div_cnt == 2'(omc_pkg::OSC_SLOW_DIV - 1)) ? 2'h0 :
			div_cnt + 2'h1;
		next_cyc_cnt = cyc_cnt;
		if (tick)
			next_cyc_cnt = (cyc_cnt == 16'(CYCLIC_PERIOD - 1)) ? 16'h0 :
				cyc_cnt + 16'h1;
		unique case (state)
		omc_pkg::OMC_RESET: begin
			if (timer >= 32'(RESET_DURATION_CYC - 1)) begin
				next_state = omc_pkg::OMC_NREQ;
				next_timer = 32'h0;
			end else
				next_timer = timer + 32'h1;
		end
		omc_pkg::OMC_NREQ: begin
			if (wd_period_write) begin
				next_wd_config = wd_period;
				next_state = (mode_cmd.valid &&
					mode_cmd.mode == omc_pkg::CMD_STANDBY) ?
					omc_pkg::OMC_STANDBY : omc_pkg::OMC_NORMAL;
			end else if (timer >= 32'(CONFIG_TIMEOUT_CYC - 1)) begin
				next_timer = 32'h0;
				next_state = from_sleep ? omc_pkg::OMC_SLEEP :
					omc_pkg::OMC_RESET;
			end else
				next_timer = timer + 32'h1;
		end
		omc_pkg::OMC_NORMAL, omc_pkg::OMC_STANDBY: begin
			if (mode_cmd.valid) begin
				unique case (mode_cmd.mode)
				omc_pkg::CMD_NORMAL: next_state = omc_pkg::OMC_NORMAL;
				omc_pkg::CMD_STANDBY: next_state = omc_pkg::OMC_STANDBY;
				omc_pkg::CMD_STOP: next_state = omc_pkg::OMC_STOP;
				omc_pkg::CMD_SLEEP: next_state = omc_pkg::OMC_SLEEP;
				endcase
			end
		end
		omc_pkg::OMC_STOP: begin
			if (stop_wake) begin
				next_state = omc_pkg::OMC_NREQ;
				next_timer = 32'h0;
				next_from_sleep = 1'b0;
				next_pulse_cnt = 16'(omc_pkg::WAKE_PULSE_CYC);
			end
		end
		omc_pkg::OMC_SLEEP: begin
			if (sleep_wake) begin
				next_state = omc_pkg::OMC_RESET;
				next_timer = 32'h0;
				next_from_sleep = 1'b1;
			end
		end
		default: begin
			next_state = omc_pkg::OMC_RESET;
			next_timer = 32'h0;
		end
		endcase
		// Reset conditions override the mode machine in every state except Sleep and Reset
		if (state != omc_pkg::OMC_SLEEP && state != omc_pkg::OMC_RESET &&
			(vdd_uv || (watchdog_run && (wd_timeout ||
			wd_closed_trigger)))) begin
			next_state = omc_pkg::OMC_RESET;
			next_timer = 32'h0;
			next_from_sleep = 1'b0;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= omc_pkg::OMC_RESET;
			timer <= 32'h0;
			from_sleep <= 1'b0;
			pulse_cnt <= 16'h0;
			cyc_cnt <= 16'h0;
			div_cnt <= 2'h0;
			wd_config <= 4'h0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			from_sleep <= next_from_sleep;
			pulse_cnt <= next_pulse_cnt;
			cyc_cnt <= next_cyc_cnt;
			div_cnt <= next_div_cnt;
			wd_config <= next_wd_config;
		end
	end
	// ------------------------------------------------
	// Outputs and flags
	// ------------------------------------------------
	logic next_second_supply_low_flag, next_switch_overtemp_flag, next_irq, next_can_wake_flag, next_hs;
	logic in_low;
	assign in_low = next_state inside {omc_pkg::OMC_SLEEP, omc_pkg::OMC_STOP};
	always_comb begin
		next_second_supply_low_flag = v2_uv | (second_supply_low_flag & ~flag_clear);
		next_switch_overtemp_flag = hs_ot | (switch_overtemp_flag & ~flag_clear);
		next_irq = hs_ot | v2_uv |
			(switch_overtemp_or_supply_low_irq & ~flag_clear);
		next_can_wake_flag = (state == omc_pkg::OMC_STANDBY && can_rx) |
			(can_wake_flag & ~flag_clear);
		next_hs = 1'b0;
		if (!hs_ot && next_state != omc_pkg::OMC_RESET &&
			next_state != omc_pkg::OMC_NREQ)
			next_hs = in_low ? (switch_output_on_bit &&
				cyc_cnt < 16'(CYCLIC_ON))
				: switch_output_on_bit;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode <= 6'h01;
			reset_n <= 1'b0;
			irq_n <= 1'b1;
			main_regulator_on <= 1'b0;
			main_regulator_keepalive <= 1'b0;
			second_regulator_drive <= 1'b0;
			switched_battery_output <= 1'b0;
			can_tx_enable <= 1'b0;
			watchdog_run <= 1'b0;
			slow_osc_select <= 1'b0;
			second_supply_low_flag <= 1'b0;
			switch_overtemp_flag <= 1'b0;
			switch_overtemp_or_supply_low_irq <= 1'b0;
			can_wake_flag <= 1'b0;
		end else begin
			mode <= next_state;
			reset_n <= next_state != omc_pkg::OMC_RESET;
			irq_n <= next_pulse_cnt == 16'h0;
			main_regulator_on <= next_state != omc_pkg::OMC_SLEEP &&
				next_state != omc_pkg::OMC_RESET;
			main_regulator_keepalive <= next_state == omc_pkg::OMC_STOP;
			second_regulator_drive <= next_state == omc_pkg::OMC_NORMAL;
			switched_battery_output <= next_hs;
			can_tx_enable <= next_state == omc_pkg::OMC_NORMAL;
			watchdog_run <= next_state == omc_pkg::OMC_NORMAL ||
				next_state == omc_pkg::OMC_STANDBY ||
				(next_state == omc_pkg::OMC_STOP &&
				stop_watchdog_enable);
			slow_osc_select <= in_low;
			second_supply_low_flag <= next_second_supply_low_flag;
			switch_overtemp_flag <= next_switch_overtemp_flag;
			switch_overtemp_or_supply_low_irq <= next_irq;
			can_wake_flag <= next_can_wake_flag;
		end
	end
	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	property p_reset_low;
		@(posedge clk) disable iff (reset)
		(mode == 6'h01) |-> !reset_n;
	endproperty
	a_reset_low: assert property (p_reset_low)
		else $error("reset_n high in Reset");
	property p_nreq_outs;
		@(posedge clk) disable iff (reset)
		(mode == 6'h02) |-> reset_n && main_regulator_on &&
			!second_regulator_drive;
	endproperty
	a_nreq_outs: assert property (p_nreq_outs)
		else $error("bad Request outputs");
	property p_standby;
		@(posedge clk) disable iff (reset)
		(mode == 6'h08) |-> main_regulator_on && !second_regulator_drive &&
			!can_tx_enable && watchdog_run;
	endproperty
	a_standby: assert property (p_standby)
		else $error("bad Standby outputs");
	property p_normal;
		@(posedge clk) disable iff (reset)
		(mode == 6'h04) |-> main_regulator_on && second_regulator_drive &&
			watchdog_run;
	endproperty
	a_normal: assert property (p_normal)
		else $error("bad Normal outputs");
	property p_stop_entry;
		@(posedge clk) disable iff (reset)
		(mode == 6'h10 && $past(mode) != 6'h10) |->
			$past(mode_cmd.valid) && $past(mode_cmd.mode) == 2'h2;
	endproperty
	a_stop_entry: assert property (p_stop_entry)
		else $error("Stop without command");
	property p_sleep;
		@(posedge clk) disable iff (reset)
		(mode == 6'h20) |-> !main_regulator_on && !second_regulator_drive &&
			slow_osc_select;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("bad Sleep outputs");
	property p_stop_wake;
		@(posedge clk) disable iff (reset)
		(mode == 6'h10 && stop_wake && !vdd_uv &&
			!(watchdog_run && (wd_timeout || wd_closed_trigger))) |=>
			(mode == 6'h02) ##1 !irq_n;
	endproperty
	a_stop_wake: assert property (p_stop_wake)
		else $error("bad Stop wake");
	property p_second_supply_low_flag;
		@(posedge clk) disable iff (reset)
		v2_uv |=> second_supply_low_flag && switch_overtemp_or_supply_low_irq;
	endproperty
	a_second_supply_low_flag: assert property (p_second_supply_low_flag)
		else $error("supply low flag missed");
	property p_stop_wd;
		@(posedge clk) disable iff (reset)
		(mode == 6'h10) |-> watchdog_run == $past(stop_watchdog_enable);
	endproperty
	a_stop_wd: assert property (p_stop_wd)
		else $error("Stop watchdog wrong");
endmodule

// ==== src/omc_pkg.sv ====
// Package for the operating mode controller
package omc_pkg;
	// ------------------------------------------------
	// Mode states, one-hot
	// ------------------------------------------------
	typedef enum logic [5:0] {
		OMC_RESET = 6'h01,
		OMC_NREQ = 6'h02,
		OMC_NORMAL = 6'h04,
		OMC_STANDBY = 6'h08,
		OMC_STOP = 6'h10,
		OMC_SLEEP = 6'h20
	} omc_mode_t;
	// ------------------------------------------------
	// Host mode commands
	// ------------------------------------------------
	localparam logic [1:0] CMD_NORMAL = 2'h0;
	localparam logic [1:0] CMD_STANDBY = 2'h1;
	localparam logic [1:0] CMD_STOP = 2'h2;
	localparam logic [1:0] CMD_SLEEP = 2'h3;
	// ------------------------------------------------
	// Timing
	// ------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int RESET_DURATION_MS = 15;
	localparam int CONFIG_TIMEOUT_MS = 350;
	localparam int WAKE_PULSE_US = 10;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int RESET_DURATION_CYC = RESET_DURATION_MS * CYC_PER_MS;
	localparam int CONFIG_TIMEOUT_CYC = CONFIG_TIMEOUT_MS * CYC_PER_MS;
	localparam int WAKE_PULSE_CYC = WAKE_PULSE_US * CLK_MHZ;
	localparam int OSC_SLOW_DIV = 4;
	// ------------------------------------------------
	// Wake sources
	// ------------------------------------------------
	typedef struct packed {
		logic cyclic_sense;
		logic forced_timer;
		logic can_msg;
		logic wake_change;
		logic vdd_overcurrent;
		logic cs_activity;
	} omc_wake_t;
	typedef struct packed {
		logic [1:0] mode;
		logic valid;
	} omc_cmd_t;
endpackage

// ==== bench/omc_host.sv ====
// Host microcontroller model driving mode commands and watchdog setup
`timescale 1ns/1ps
module omc_host (
	input wire logic clk,
	output omc_pkg::omc_cmd_t mode_cmd,
	output logic wd_period_write,
	output logic [3:0] wd_period,
	output logic cs_activity
);
	// ------------------------------------------------
	// Idle state
	// ------------------------------------------------
	initial begin
		mode_cmd = 3'h0;
		wd_period_write = 1'b0;
		wd_period = 4'h0;
		cs_activity = 1'b0;
	end
	// ------------------------------------------------
	// Access tasks
	// ------------------------------------------------
	// Mode command, the only way into Stop
	task cmd(input logic [1:0] m);
		@(posedge clk);
		mode_cmd <= {m, 1'b1};
		@(posedge clk);
		mode_cmd <= {~m, 1'b0};
	endtask
	// Watchdog period setup, optionally with a Standby request
	task period(input logic [3:0] p, input logic stby);
		@(posedge clk);
		wd_period_write <= 1'b1;
		wd_period <= p;
		mode_cmd <= {omc_pkg::CMD_STANDBY, stby};
		@(posedge clk);
		wd_period_write <= 1'b0;
		wd_period <= ~p;
		mode_cmd <= {~omc_pkg::CMD_STANDBY, 1'b0};
	endtask
	// Chip select activity wakes the device from Stop only; it is not a Sleep wake source
	task cs_wake;
		@(posedge clk);
		cs_activity <= 1'b1;
		repeat (4) @(posedge clk);
		cs_activity <= 1'b0;
	endtask
endmodule

// ==== bench/tb.sv ====
// Testbench for the operating mode controller
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	fail_count++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb;
	logic clk = 0;
	logic reset = 1;
	omc_pkg::omc_cmd_t mode_cmd;
	logic wd_period_write, cs;
	logic [3:0] wd_period, wd_config;
	logic wd_timeout = 0, wd_closed_trigger = 0, stop_watchdog_enable = 0;
	logic switch_output_on_bit = 0, flag_clear = 0, vdd_uv = 0, v2_uv = 0;
	logic ot = 0, can_rx_msg = 0;
	logic [4:0] wk = 0;
	omc_pkg::omc_wake_t wake_pins;
	logic [5:0] mode;
	logic reset_n, irq_n, main_regulator_on, main_regulator_keepalive;
	logic second_regulator_drive, switched_battery_output, can_tx_enable;
	logic watchdog_run, slow_osc_select, second_supply_low_flag;
	logic switch_overtemp_flag, switch_overtemp_or_supply_low_irq;
	logic can_wake_flag;
	int fail_count = 0, check_count = 0, hi;
	int low_run = 0, last_run = 0;
	assign wake_pins = {wk, cs};
	always #2.5 clk = ~clk;
	omc_host host (.clk, .mode_cmd, .wd_period_write, .wd_period,
		.cs_activity(cs));
	omc_top #(.RESET_DURATION_CYC(20), .CONFIG_TIMEOUT_CYC(50),
		.CYCLIC_PERIOD(32), .CYCLIC_ON(4)) uut (.clk, .reset, .mode_cmd,
		.wd_period_write, .wd_period, .wd_timeout, .wd_closed_trigger,
		.stop_watchdog_enable, .switch_output_on_bit, .flag_clear,
		.vdd_undervoltage_pin(vdd_uv), .second_supply_undervoltage_pin(v2_uv),
		.switch_overtemp_pin(ot), .wake_pins, .can_rx_msg, .mode, .reset_n,
		.irq_n, .main_regulator_on, .main_regulator_keepalive,
		.second_regulator_drive, .switched_battery_output, .can_tx_enable,
		.watchdog_run, .slow_osc_select, .second_supply_low_flag,
		.switch_overtemp_flag, .switch_overtemp_or_supply_low_irq,
		.can_wake_flag, .wd_config);
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task wait_mode(input logic [5:0] m, input int lim);
		int i;
		i = 0;
		@(negedge clk);
		while (mode !== m && i < lim) begin
			@(negedge clk);
			i++;
		end
		`CHK(mode, m)
	endtask
	// Length of the last low pulse on irq_n, in clock cycles
	always @(negedge clk) begin
		if (!irq_n) begin
			low_run <= low_run + 1;
		end else begin
			if (low_run != 0)
				last_run <= low_run;
			low_run <= 0;
		end
	end
	task wait_irq;
		int n;
		n = 0;
		while (irq_n !== 1'b1 && n < 2100) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		`CHK(last_run, omc_pkg::WAKE_PULSE_CYC)
	endtask
	task results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task to_normal(input logic [3:0] p);
		wait_mode(omc_pkg::OMC_NREQ, 40);
		host.period(p, 1'b0);
		wait_mode(omc_pkg::OMC_NORMAL, 5);
		`CHK(wd_config, p)
	endtask
	initial begin
		#200000;
		fail_count++;
		results;
	end
	// ------------------------------------------------
	// Tests
	// ------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		@(negedge clk);
		`CHK(mode, omc_pkg::OMC_RESET)
		`CHK(reset_n, 1'b0)
		wait_mode(omc_pkg::OMC_NREQ, 40);
		`CHK({reset_n, main_regulator_on, second_regulator_drive}, 3'h6)
		host.cmd(omc_pkg::CMD_STOP);
		repeat (30) @(negedge clk);
		`CHK(mode, omc_pkg::OMC_NREQ)
		wait_mode(omc_pkg::OMC_RESET, 30);
		$display("power-up and timeout done");
		wait_mode(omc_pkg::OMC_NREQ, 40);
		host.period(4'h5, 1'b1);
		wait_mode(omc_pkg::OMC_STANDBY, 5);
		`CHK(wd_config, 4'h5)
		`CHK({main_regulator_on, second_regulator_drive}, 2'h2)
		`CHK({can_tx_enable, watchdog_run, slow_osc_select}, 3'h2)
		@(posedge clk) can_rx_msg <= 1;
		repeat (4) @(posedge clk);
		can_rx_msg <= 0;
		@(negedge clk);
		`CHK(can_wake_flag, 1'b1)
		host.cmd(omc_pkg::CMD_NORMAL);
		wait_mode(omc_pkg::OMC_NORMAL, 5);
		`CHK({second_regulator_drive, can_tx_enable, watchdog_run}, 3'h7)
		@(posedge clk);
		switch_output_on_bit <= 1;
		{v2_uv, ot} <= 2'h3;
		repeat (5) @(negedge clk);
		`CHK(second_supply_low_flag, 1'b1)
		`CHK({switch_overtemp_flag, switch_overtemp_or_supply_low_irq}, 2'h3)
		@(posedge clk) {v2_uv, ot} <= 2'h0;
		repeat (4) @(posedge clk);
		flag_clear <= 1;
		@(posedge clk) flag_clear <= 0;
		repeat (3) @(negedge clk);
		`CHK({second_supply_low_flag, switch_overtemp_flag}, 2'h0)
		`CHK(switched_battery_output, 1'b1)
		$display("standby and normal done");
		for (int i = 0; i < 6; i++) begin
			@(posedge clk) stop_watchdog_enable <= i[0];
			host.cmd(omc_pkg::CMD_STOP);
			wait_mode(omc_pkg::OMC_STOP, 5);
			`CHK({main_regulator_keepalive, second_regulator_drive}, 2'h2)
			`CHK(slow_osc_select, 1'b1)
			`CHK(watchdog_run, i[0])
			hi = 0;
			if (i == 5) begin
				repeat (600) @(negedge clk) hi += switched_battery_output;
				// On 16 of every 128 cycles: 4 ticks of 4 cycles
				`CHK(hi inside {[64:80]}, 1'b1)
			end
			if (i == 0) begin
				host.cs_wake();
			end else begin
				@(posedge clk) wk[i-1] <= 1;
				repeat (4) @(posedge clk);
				wk[i-1] <= 0;
			end
			wait_mode(omc_pkg::OMC_NREQ, 10);
			`CHK(irq_n, 1'b0)
			to_normal(i[3:0]);
			wait_irq();
		end
		$display("stop wake done");
		host.cmd(omc_pkg::CMD_SLEEP);
		wait_mode(omc_pkg::OMC_SLEEP, 5);
		`CHK({main_regulator_on, second_regulator_drive}, 2'h0)
		for (int i = 1; i < 5; i++) begin
			@(posedge clk) wk[i] <= 1;
			repeat (4) @(posedge clk);
			wk[i] <= 0;
			wait_mode(omc_pkg::OMC_RESET, 10);
			wait_mode(omc_pkg::OMC_NREQ, 40);
			if (i < 4) begin
				wait_mode(omc_pkg::OMC_SLEEP, 60);
			end
		end
		to_normal(4'ha);
		$display("sleep done");
		@(posedge clk) wd_timeout <= 1;
		@(posedge clk) wd_timeout <= 0;
		wait_mode(omc_pkg::OMC_RESET, 5);
		to_normal(4'h3);
		@(posedge clk) wd_closed_trigger <= 1;
		@(posedge clk) wd_closed_trigger <= 0;
		wait_mode(omc_pkg::OMC_RESET, 5);
		to_normal(4'hc);
		@(posedge clk) vdd_uv <= 1;
		wait_mode(omc_pkg::OMC_RESET, 8);
		@(posedge clk) vdd_uv <= 0;
		to_normal(4'hf);
		$display("reset sources done");
		results;
	end
endmodule
